// [logic/mmap_regs.svh]
// Address map, page and timing constants for the memory-map page arbiter
`ifndef MMAP_REGS_SVH
`define MMAP_REGS_SVH
`define GADDR_W 18
`define LADDR_W 16
`define PAGE_W 8
`define REG_BOTTOM 18'h0_0000
`define REG_TOP 18'h0_03FF
`define RAM_END_PLUS1 18'h0_4000
`define RAM_TOP 18'h0_3FFF
`define RAM_MAX_BYTES 32'h0000_2C00
`define DF_BOTTOM 18'h0_4400
`define DF_TOP 18'h0_53FF
`define PF_END_PLUS1 32'h0004_0000
`define PF_TOP 18'h3_FFFF
`define PF_MAX_BYTES 32'h0003_8000
`define INFO_ROW_PAGE 8'h01
`define INFO_ROW_MAX_BYTES 32'h0000_4000
`define PAGE_RESET 8'h0E
`define WIN_LOW 16'h8000
`define WIN_HIGH 16'hBFFF
`define WIN_SEL_BIT 14
`define FIXED_PAGE_0 8'h0C
`define FIXED_PAGE_1 8'h0D
`define FIXED_PAGE_3 8'h0F
`define STARVE_LIMIT 8'h80
`endif

// [logic/mmap_pkg.sv]
// Types shared by the memory-map page arbiter
package mmap_pkg;
    typedef struct packed {
        logic req;
        logic wr;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mreq_t;
    typedef struct packed {
        logic req;
        logic wr;
        logic word;
        logic [17:0] addr;
        logic [15:0] wdata;
    } treq_t;
    typedef enum logic [6:0] {
        SEQ_IDLE = 7'b0000001,
        SEQ_SAVE = 7'b0000010,
        SEQ_PUSH_RET = 7'b0000100,
        SEQ_PUSH_PG = 7'b0001000,
        SEQ_POP_PG = 7'b0010000,
        SEQ_POP_RET = 7'b0100000,
        SEQ_WR_PG = 7'b1000000
    } seq_t;
endpackage

// [logic/addr_decode.sv]
// Local to global translation and region decode for one master
`timescale 1ns/10ps
`include "mmap_regs.svh"
module addr_decode #(
    parameter int RAM_BYTES = 32'h0000_2C00,
    parameter int PF_BYTES = 32'h0003_8000
) (
    input wire logic [15:0] laddr_i,
    input wire logic [7:0] page_i,
    output logic [17:0] gaddr_o,
    output logic hit_o
);
    import mmap_pkg::*;
    logic [7:0] pg;
    logic [17:0] ram_low;
    logic [17:0] program_flash_base_address;
    assign ram_low = 18'(`RAM_END_PLUS1 - 18'(RAM_BYTES));
    assign program_flash_base_address = 18'(`PF_END_PLUS1 - 32'(PF_BYTES));
    always_comb begin
        case (laddr_i[15:14])
            2'b00: pg = `FIXED_PAGE_0;
            2'b01: pg = `FIXED_PAGE_1;
            2'b10: pg = page_i;
            default: pg = `FIXED_PAGE_3;
        endcase
        // Fixed low page uses direct global addresses for regs and RAM
        if (laddr_i[15:14] == 2'b00) begin
            gaddr_o = {2'b00, laddr_i};
        end else begin
            gaddr_o = {pg[3:0], laddr_i[13:0]};
        end
    end
    always_comb begin
        hit_o = 1'b0;
        if (gaddr_o <= `REG_TOP) begin
            hit_o = 1'b1;
        end
        if (gaddr_o >= ram_low && gaddr_o <= `RAM_TOP) begin
            hit_o = 1'b1;
        end
        if (gaddr_o >= `DF_BOTTOM && gaddr_o <= `DF_TOP) begin
            hit_o = 1'b1;
        end
        if (gaddr_o >= program_flash_base_address) begin
            hit_o = 1'b1;
        end
        if (pg == `INFO_ROW_PAGE && laddr_i[15:14] == 2'b10) begin
            hit_o = 1'b1;
        end
    end
endmodule

// [logic/memory_map_page_arbiter.sv]
// Memory-map controller: decode, crossbar port zero arbitration, paged call/return
// How it works
// - Register region of 1 kB is served by crossbar port zero.
// - System RAM up to 11 kB is served by crossbar port zero.
// - Fixed 4 kB data flash sits in the map on port zero.
// - Program flash up to 224 kB ends at 0x3_FFFF, base 0x4_0000 minus size.
// - RAM ends at 0x0_3FFF and starts at 0x0_4000 minus its size.
// - Info flash rows, data flash included, at most 16 kB on page 0x01.
// - Processor access to unimplemented space resets the system in single-chip mode, except firmware.
// - Debug master access to unimplemented space completes, no reset, data undefined.
// - Controller drives master buses and swaps processor read byte lanes.
// - Only one master owns the target bus at any time.
// - Processor wins normal contention with the debug master.
// - Debug master stalled over 128 cycles gains priority after processor op.
// - The controller raises no interrupts.
// - Page index picks one of 16 pages in a 16 kB window.
// - Paged call saves page, loads new, pushes return, pushes page, jumps.
// - Paged call and return run to completion without taking interrupts.
// - New page comes from immediate operand, or memory in indirect forms.
// - Paged return pops page, pops return to PC, writes page, resumes.
// - Page window is 0x8000 to 0xBFFF, four index bits select block.
// - Page index resets to 0x0E for linear flash after reset.
`timescale 1ns/10ps
`include "mmap_regs.svh"
module memory_map_page_arbiter #(
    parameter int RAM_BYTES = 32'h0000_2C00,
    parameter int PF_BYTES = 32'h0003_8000,
    parameter int STARVE = 128
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic single_chip_i,
    input wire logic firmware_cmd_i,
    input wire mmap_pkg::mreq_t cpu_req_i,
    input wire logic cpu_op_end_i,
    output logic cpu_grant_o,
    output logic [15:0] cpu_rdata_o,
    input wire mmap_pkg::mreq_t dbg_req_i,
    output logic dbg_grant_o,
    output logic [15:0] dbg_rdata_o,
    output mmap_pkg::treq_t xbar_zero_o,
    input wire logic [15:0] xbar_zero_rdata_i,
    input wire logic call_i,
    input wire logic rtc_i,
    input wire logic indirect_i,
    input wire logic [7:0] imm_page_i,
    input wire logic [7:0] mem_page_i,
    input wire logic [15:0] ret_addr_i,
    input wire logic [15:0] stack_page_i,
    input wire logic [15:0] stack_ret_i,
    output logic seq_busy_o,
    output logic irq_block_o,
    output logic push_o,
    output logic pop_o,
    output logic [15:0] push_data_o,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic queue_refill_o,
    output logic [7:0] program_page_index_o,
    output logic illegal_reset_o,
    output logic irq_o
);
    import mmap_pkg::*;

    initial begin
        if (RAM_BYTES > `RAM_MAX_BYTES || PF_BYTES > `PF_MAX_BYTES || STARVE < 1 || STARVE > 255)
            $error("Unsupported memory sizes or starvation limit");
    end

    seq_t seq_ff;
    logic [7:0] program_page_index_ff;
    logic [7:0] tmp_page_ff;
    logic [7:0] starve_ff;
    logic dbg_prio_ff;
    logic owner_dbg_ff;
    logic owner_busy_ff;
    logic [15:0] cpu_rdata_ff;
    logic [15:0] dbg_rdata_ff;
    logic illegal_ff;
    logic [17:0] cpu_gaddr;
    logic [17:0] dbg_gaddr;
    logic cpu_hit;
    logic pick_dbg;
    logic pick_cpu;

    function automatic logic [15:0] lane_swap(input logic [15:0] d, input logic odd, input logic w);
        lane_swap = (!w && odd) ? {8'h00, d[7:0]} : (!w ? {8'h00, d[15:8]} : d);
    endfunction

    addr_decode #(.RAM_BYTES(RAM_BYTES), .PF_BYTES(PF_BYTES)) u_cpu_dec (
        .laddr_i(cpu_req_i.addr),
        .page_i(program_page_index_ff),
        .gaddr_o(cpu_gaddr),
        .hit_o(cpu_hit)
    );
    addr_decode #(.RAM_BYTES(RAM_BYTES), .PF_BYTES(PF_BYTES)) u_dbg_dec (
        .laddr_i(dbg_req_i.addr),
        .page_i(program_page_index_ff),
        .gaddr_o(dbg_gaddr),
        .hit_o()
    );

    // Debug wins against a requesting processor only once starved; the processor keeps the bus till its op ends
    assign pick_dbg = dbg_req_i.req && (!cpu_req_i.req || dbg_prio_ff) &&
                      !(owner_busy_ff && !owner_dbg_ff && !cpu_op_end_i);
    assign pick_cpu = cpu_req_i.req && !pick_dbg;
    assign cpu_grant_o = pick_cpu;
    assign dbg_grant_o = pick_dbg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            starve_ff <= 8'h00;
            dbg_prio_ff <= 1'b0;
        end else if (!dbg_req_i.req || pick_dbg) begin
            starve_ff <= 8'h00;
            dbg_prio_ff <= 1'b0;
        end else if (starve_ff < 8'(STARVE)) begin
            starve_ff <= starve_ff + 8'h01;
        end else begin
            dbg_prio_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            owner_busy_ff <= 1'b0;
            owner_dbg_ff <= 1'b0;
        end else begin
            owner_busy_ff <= pick_cpu && !cpu_op_end_i;
            owner_dbg_ff <= pick_dbg;
        end
    end

    always_comb begin
        xbar_zero_o = '0;
        if (pick_dbg) begin
            xbar_zero_o = '{req: 1'b1, wr: dbg_req_i.wr, word: dbg_req_i.word,
                            addr: dbg_gaddr, wdata: dbg_req_i.wdata};
        end else if (pick_cpu) begin
            xbar_zero_o = '{req: 1'b1, wr: cpu_req_i.wr, word: cpu_req_i.word,
                            addr: cpu_gaddr, wdata: cpu_req_i.wdata};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cpu_rdata_ff <= 16'h0000;
            dbg_rdata_ff <= 16'h0000;
        end else begin
            if (pick_cpu && !cpu_req_i.wr) begin
                cpu_rdata_ff <= lane_swap(xbar_zero_rdata_i, cpu_req_i.addr[0],
                                          cpu_req_i.word);
            end
            // Unmapped debug reads just return whatever the port shows
            if (pick_dbg && !dbg_req_i.wr) begin
                dbg_rdata_ff <= xbar_zero_rdata_i;
            end
        end
    end
    assign cpu_rdata_o = cpu_rdata_ff;
    assign dbg_rdata_o = dbg_rdata_ff;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= pick_cpu && !cpu_hit && single_chip_i && !firmware_cmd_i;
        end
    end
    assign illegal_reset_o = illegal_ff;
    assign irq_o = 1'b0;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            seq_ff <= SEQ_IDLE;
            program_page_index_ff <= `PAGE_RESET;
            tmp_page_ff <= 8'h00;
        end else begin
            case (seq_ff)
                SEQ_IDLE: begin
                    if (call_i) begin
                        tmp_page_ff <= program_page_index_ff;
                        program_page_index_ff <= indirect_i ? mem_page_i : imm_page_i;
                        seq_ff <= SEQ_PUSH_RET;
                    end else if (rtc_i) begin
                        seq_ff <= SEQ_POP_PG;
                    end
                end
                SEQ_PUSH_RET: seq_ff <= SEQ_PUSH_PG;
                SEQ_PUSH_PG: seq_ff <= SEQ_SAVE;
                SEQ_SAVE: seq_ff <= SEQ_IDLE;
                SEQ_POP_PG: begin
                    tmp_page_ff <= stack_page_i[7:0];
                    seq_ff <= SEQ_POP_RET;
                end
                SEQ_POP_RET: seq_ff <= SEQ_WR_PG;
                SEQ_WR_PG: begin
                    program_page_index_ff <= tmp_page_ff;
                    seq_ff <= SEQ_SAVE;
                end
                default: seq_ff <= SEQ_IDLE;
            endcase
        end
    end

    always_comb begin
        push_o = 1'b0;
        pop_o = 1'b0;
        push_data_o = 16'h0000;
        pc_load_o = 1'b0;
        pc_value_o = 16'h0000;
        queue_refill_o = 1'b0;
        case (seq_ff)
            SEQ_PUSH_RET: begin
                push_o = 1'b1;
                push_data_o = ret_addr_i;
            end
            SEQ_PUSH_PG: begin
                push_o = 1'b1;
                push_data_o = {8'h00, tmp_page_ff};
            end
            SEQ_POP_PG: pop_o = 1'b1;
            SEQ_POP_RET: begin
                pop_o = 1'b1;
                pc_load_o = 1'b1;
                pc_value_o = stack_ret_i;
            end
            SEQ_SAVE: queue_refill_o = 1'b1;
            default: queue_refill_o = 1'b0;
        endcase
    end
    assign seq_busy_o = seq_ff != SEQ_IDLE;
    assign irq_block_o = seq_ff != SEQ_IDLE;
    assign program_page_index_o = program_page_index_ff;

    a_single_owner: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(cpu_grant_o && dbg_grant_o)) else $error("Two masters granted");
    a_cpu_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cpu_req_i.req && dbg_req_i.req && !dbg_prio_ff) |-> cpu_grant_o)
        else $error("Processor lost normal contention");
    a_starve_prio: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (dbg_req_i.req && !dbg_grant_o && starve_ff == 8'(STARVE)) |=> dbg_prio_ff || !dbg_req_i.req
        || dbg_grant_o) else $error("Starved debug not promoted");
    a_starve_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!dbg_req_i.req || dbg_grant_o) |=> starve_ff == 8'h00) else $error("Counter kept");
    a_illegal_rst: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cpu_grant_o && !cpu_hit && single_chip_i && !firmware_cmd_i) |=> illegal_reset_o)
        else $error("Missing illegal reset");
    a_dbg_noreset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dbg_grant_o |=> !illegal_reset_o || $past(cpu_grant_o)) else $error("Debug reset");
    a_no_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !irq_o) else $error("Interrupt raised");
    a_call_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (seq_ff == SEQ_IDLE && call_i) |=> push_o && push_data_o == ret_addr_i ##1
        push_o && push_data_o[7:0] == $past(program_page_index_o, 2) ##1 queue_refill_o)
        else $error("Call order wrong");
    a_rtc_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (seq_ff == SEQ_IDLE && !call_i && rtc_i) |=> pop_o ##1 pc_load_o ##1 seq_busy_o ##1
        queue_refill_o) else $error("Return order wrong");
    a_atomic_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_busy_o |-> irq_block_o) else $error("Sequence interruptible");
    a_page_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(rst_i) |-> program_page_index_o == `PAGE_RESET) else $error("Bad page reset");
endmodule

// [bench/xbar_target_model.sv]
// Behavioural target memory on crossbar port zero
`timescale 1ns/10ps
module xbar_target_model (
    input wire logic clk_sys_i,
    input wire mmap_pkg::treq_t xbar_zero_i,
    output logic [15:0] rdata_o
);
    import mmap_pkg::*;
    logic [15:0] idle_ff = 16'hC3C3;
    // Idle bus toggles so stale data never looks valid
    always @(posedge clk_sys_i) begin
        idle_ff <= ~idle_ff;
    end
    // Content is a fixed scramble of the global address, served same cycle
    assign rdata_o = xbar_zero_i.req ? (xbar_zero_i.addr[15:0] ^ 16'h5A3C) : idle_ff;
endmodule

// [bench/memory_map_page_arbiter_tb.sv]
// Self-checking bench for the memory-map page arbiter
`timescale 1ns/10ps
module memory_map_page_arbiter_tb;
    import mmap_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic single_chip_i = 1'b1;
    logic firmware_cmd_i = 1'b0;
    logic cpu_op_end_i = 1'b1;
    logic call_i = 1'b0;
    logic rtc_i = 1'b0;
    logic indirect_i = 1'b0;
    mreq_t cpu_req_i = '0;
    mreq_t dbg_req_i = '0;
    treq_t xbar_zero_o;
    logic [7:0] imm_page_i = 8'h00;
    logic [7:0] mem_page_i = 8'h00;
    logic [7:0] program_page_index_o;
    logic [15:0] ret_addr_i = 16'h0000;
    logic [15:0] stack_page_i = 16'h0000;
    logic [15:0] stack_ret_i = 16'h0000;
    logic [15:0] xbar_zero_rdata_i, cpu_rdata_o, dbg_rdata_o, push_data_o, pc_value_o;
    logic cpu_grant_o, dbg_grant_o, seq_busy_o, irq_block_o, push_o, pop_o;
    logic pc_load_o, queue_refill_o, illegal_reset_o, irq_o;
    int failures = 0;
    int checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    // Short starvation limit keeps the override scenario brief
    memory_map_page_arbiter #(.STARVE(4)) memory_map_page_arbiter_i (
        .clk_sys_i, .rst_i, .single_chip_i, .firmware_cmd_i, .cpu_req_i, .cpu_op_end_i,
        .cpu_grant_o, .cpu_rdata_o, .dbg_req_i, .dbg_grant_o, .dbg_rdata_o, .xbar_zero_o,
        .xbar_zero_rdata_i, .call_i, .rtc_i, .indirect_i, .imm_page_i, .mem_page_i,
        .ret_addr_i, .stack_page_i, .stack_ret_i, .seq_busy_o, .irq_block_o, .push_o,
        .pop_o, .push_data_o, .pc_load_o, .pc_value_o, .queue_refill_o,
        .program_page_index_o, .illegal_reset_o, .irq_o
    );
    xbar_target_model xbar_target_model_i (
        .clk_sys_i(clk_sys_i),
        .xbar_zero_i(xbar_zero_o),
        .rdata_o(xbar_zero_rdata_i)
    );

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [17:0] exp, input logic [17:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One read held until granted; counts reset pulses in the following cycles
    task automatic access(input logic dbg, input logic [15:0] a, input logic w,
                          output logic [17:0] ta, output logic [15:0] rd, output int np);
        mreq_t q;
        int n;
        q = '{req: 1'b1, wr: 1'b0, word: w, addr: a, wdata: 16'h0000};
        np = 0;
        n = 0;
        if (dbg) dbg_req_i <= q;
        else cpu_req_i <= q;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while ((dbg ? dbg_grant_o : cpu_grant_o) !== 1'b1 && n < 50);
        chk_bit("grant", 1'b1, dbg ? dbg_grant_o : cpu_grant_o);
        ta = xbar_zero_o.addr;
        @(posedge clk_sys_i);
        if (dbg) dbg_req_i <= '0;
        else cpu_req_i <= '0;
        repeat (3) begin
            #1;
            if (illegal_reset_o === 1'b1) np++;
            @(posedge clk_sys_i);
        end
        #1;
        rd = dbg ? dbg_rdata_o : cpu_rdata_o;
    endtask
    task automatic rd_chk(input logic dbg, input logic [15:0] a, input logic w,
                          input logic [17:0] ga, input int exp_np, input logic known);
        logic [17:0] ta;
        logic [15:0] rd;
        logic [15:0] ex;
        int np;
        access(dbg, a, w, ta, rd, np);
        ex = ga[15:0] ^ 16'h5A3C;
        if (!w) ex = {8'h00, a[0] ? ex[7:0] : ex[15:8]};
        if (!w) rd[15:8] = 8'h00;
        chk_val("reset pulses", 18'(exp_np), 18'(np));
        if (known) begin
            chk_val("target address", ga, ta);
            chk_val("read data", {2'b00, ex}, {2'b00, rd});
        end
    endtask

    task automatic do_call(input logic ind, input logic [7:0] imm, input logic [7:0] mem,
                           input logic [15:0] ret);
        logic [7:0] old;
        old = program_page_index_o;
        indirect_i <= ind;
        imm_page_i <= imm;
        mem_page_i <= mem;
        ret_addr_i <= ret;
        call_i <= 1'b1;
        @(posedge clk_sys_i);
        call_i <= 1'b0;
        #1;
        chk_val("new page", {10'h000, ind ? mem : imm}, {10'h000, program_page_index_o});
        chk_bit("push return", 1'b1, push_o);
        chk_val("return word", {2'b00, ret}, {2'b00, push_data_o});
        chk_bit("irq held off", 1'b1, irq_block_o);
        @(posedge clk_sys_i);
        #1;
        chk_bit("push page", 1'b1, push_o);
        chk_val("page word", {10'h000, old}, {2'b00, push_data_o});
        @(posedge clk_sys_i);
        #1;
        chk_bit("refill", 1'b1, queue_refill_o);
        chk_bit("irq held off", 1'b1, irq_block_o);
        @(posedge clk_sys_i);
        #1;
        chk_bit("call done", 1'b0, seq_busy_o);
    endtask
    task automatic do_rtc(input logic [15:0] spg, input logic [15:0] sret);
        stack_page_i <= spg;
        stack_ret_i <= sret;
        rtc_i <= 1'b1;
        @(posedge clk_sys_i);
        rtc_i <= 1'b0;
        #1;
        chk_bit("pop page", 1'b1, pop_o);
        chk_bit("irq held off", 1'b1, irq_block_o);
        @(posedge clk_sys_i);
        #1;
        chk_bit("pc load", 1'b1, pc_load_o);
        chk_val("pc value", {2'b00, sret}, {2'b00, pc_value_o});
        @(posedge clk_sys_i);
        #1;
        chk_bit("no early refill", 1'b0, queue_refill_o);
        @(posedge clk_sys_i);
        #1;
        chk_bit("refill", 1'b1, queue_refill_o);
        chk_val("page back", {10'h000, spg[7:0]}, {10'h000, program_page_index_o});
        @(posedge clk_sys_i);
        #1;
        chk_bit("return done", 1'b0, seq_busy_o);
    endtask

    task automatic t_reset();
        #1;
        chk_val("reset page", 18'h0_000E, {10'h000, program_page_index_o});
        chk_bit("no irq", 1'b0, irq_o);
    endtask
    task automatic t_map();
        rd_chk(0, 16'h9000, 0, 18'h3_9000, 0, 1);
        rd_chk(0, 16'h9001, 0, 18'h3_9001, 0, 1);
        rd_chk(0, 16'h0200, 1, 18'h0_0200, 0, 1);
        rd_chk(0, 16'h1400, 1, 18'h0_1400, 0, 1);
        rd_chk(0, 16'h3FFE, 1, 18'h0_3FFE, 0, 1);
        rd_chk(0, 16'h13FE, 1, 18'h0_13FE, 1, 0);
        rd_chk(0, 16'h4000, 1, 18'h3_4000, 0, 1);
        rd_chk(1, 16'hC002, 1, 18'h3_C002, 0, 1);
        do_call(0, 8'h02, 8'h09, 16'h1234);
        rd_chk(0, 16'h8000, 1, 18'h0_8000, 0, 1);
        do_call(1, 8'h07, 8'h01, 16'h2468);
        rd_chk(0, 16'h8400, 1, 18'h0_4400, 0, 1);
        do_rtc(16'hA502, 16'h2468);
        do_rtc(16'h000E, 16'h1234);
        chk_bit("no irq", 1'b0, irq_o);
    endtask
    task automatic t_illegal();
        logic [2:0] md [4] = '{3'b100, 3'b110, 3'b000, 3'b101};
        for (int i = 0; i < 4; i++) begin
            single_chip_i <= md[i][2];
            firmware_cmd_i <= md[i][1];
            rd_chk(md[i][0], 16'h0400, 1'b1, 18'h0_0400, (i == 0), 1'b0);
        end
        single_chip_i <= 1'b1;
        firmware_cmd_i <= 1'b0;
    endtask
    task automatic t_arb();
        mreq_t c;
        mreq_t d;
        int n;
        c = '{req: 1'b1, wr: 1'b0, word: 1'b1, addr: 16'hC000, wdata: 16'h0000};
        d = '{req: 1'b1, wr: 1'b0, word: 1'b1, addr: 16'hC002, wdata: 16'h0000};
        n = 0;
        cpu_req_i <= c;
        dbg_req_i <= d;
        @(negedge clk_sys_i);
        chk_bit("cpu wins", 1'b1, cpu_grant_o);
        while (dbg_grant_o !== 1'b1 && n < 20) begin
            chk_bit("lone owner", 1'b0, cpu_grant_o & dbg_grant_o);
            @(negedge clk_sys_i);
            n++;
        end
        chk_bit("starve span", 1'b1, n > 4 && n < 9);
        chk_bit("cpu held off", 1'b0, cpu_grant_o);
        @(posedge clk_sys_i);
        dbg_req_i <= '0;
        @(posedge clk_sys_i);
        dbg_req_i <= d;
        cpu_op_end_i <= 1'b0;
        repeat (4) begin
            @(negedge clk_sys_i);
            chk_bit("count cleared", 1'b0, dbg_grant_o);
        end
        // Promoted debug still waits while the processor op is open
        repeat (3) begin
            @(negedge clk_sys_i);
            chk_bit("op not ended", 1'b0, dbg_grant_o);
        end
        @(posedge clk_sys_i);
        cpu_op_end_i <= 1'b1;
        @(negedge clk_sys_i);
        chk_bit("late priority", 1'b1, dbg_grant_o);
        @(posedge clk_sys_i);
        cpu_req_i <= '0;
        dbg_req_i <= '0;
        @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_map();
        t_illegal();
        t_arb();
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule
